// [fid_pkg.sv]
// Summary of operation
// - Drive strobes are ISA command or fast strobe
// - Fast strobes only for data-port accesses
// - Buffer enable from ISA IDE commands or fast
// - Idle pattern: ctl select high, others low
// - ISA cycle: decoded selects, ISA address bits
// - Alternate master: decoded selects, external address
// - Substitution on: address bit 2 on SBHE
// - Substitution off: SBHE keeps byte-high meaning
// - Reads of 3F7/377 take bit 7 from floppy
// - Fast cycles ignore IOCS16, always 16-bit
// - Drives 0 to 3 may route to ISA
// - Ready low at end extends the command
// - 32-bit data access becomes two transfers
// - Eight drives, four bases, two timing sets
// - Programmable read, write, recovery, setup times
// - Command select 1F0-1F7, control select 3F6-3F7
// - Drive reset is inverted system reset
// - Idle pattern only without ISA cycle or grant
// - Drive from base and select bit 4
package fid_pkg;
  localparam logic [15:0] BASE_ADDR [4] = '{16'h01F0, 16'h0170, 16'h05F0, 16'h0570};
  localparam logic [15:0] CTL_OFFSET = 16'h0206;
  localparam logic [15:0] DRVSEL_OFFSET = 16'h0006;
  localparam logic [15:0] FLOPPY_PORT_PRI = 16'h03F7;
  localparam logic [15:0] FLOPPY_PORT_SEC = 16'h0377;
  localparam int DRVSEL_BIT = 4;
  localparam logic [1:0] DEFAULT_XA = 2'h0;
  localparam logic DEFAULT_SBHE_N = 1'h0;
  localparam logic DEFAULT_CMD_SEL_N = 1'h0;
  localparam logic DEFAULT_CTL_SEL_N = 1'h1;
  localparam logic [2:0] SETUP_SAT = 3'h4;
  localparam logic [4:0] RECOV_SAT = 5'h18;
  localparam logic [3:0] RECOV_LINEAR_MAX = 4'h7;
  localparam int ISA_ROUTE_DRIVES = 4;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CMD, ST_DONE} fid_state_type;
endpackage

// [fid_fifo.sv]
`timescale 1ns/1ps
module fid_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [fid_fast_ide.sv]
`timescale 1ns/1ps
module fid_fast_ide (
  input wire logic clk,
  input wire logic reset,
  input wire logic accReq,
  input wire logic [15:0] accAddr,
  input wire logic accWrite,
  input wire logic acc32,
  input wire logic [31:0] accWrData,
  output logic accToIsa,
  output logic accAck,
  output logic rdValid,
  input wire logic rdReady,
  output logic [fid_pkg::FIFO_WIDTH-1:0] rdData,
  input wire logic [3:0] baseEnable,
  input wire logic useA2Subst,
  input wire logic [3:0] isaRouteDrive,
  input wire logic [7:0] driveTimingB,
  input wire logic [3:0] rdLenA,
  input wire logic [3:0] wrLenA,
  input wire logic [3:0] recovA,
  input wire logic [1:0] asuA,
  input wire logic [3:0] rdLenB,
  input wire logic [3:0] wrLenB,
  input wire logic [3:0] recovB,
  input wire logic [1:0] asuB,
  input wire logic isaCycleActive,
  input wire logic altMasterGrantN,
  input wire logic isaIorN,
  input wire logic isaIowN,
  input wire logic [15:0] isaAddr,
  input wire logic [1:0] isaXa,
  input wire logic isaSbheN,
  input wire logic isaData4,
  input wire logic ideReady,
  input wire logic floppyChangeBitIn,
  input wire logic [15:0] ideDataIn,
  output logic [15:0] ideDataOut,
  output logic ideDataOe,
  output logic ideReadStrobeN,
  output logic ideWriteStrobeN,
  output logic ideBufEnableN,
  output logic driveCmdSelectN,
  output logic driveCtlSelectN,
  output logic [1:0] periphAddrLow,
  output logic sbheOutN,
  output logic boardResetOut,
  output logic [7:0] mergedData,
  output logic mergeActive
);
  import fid_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic [2:0] decode(input logic [15:0] a, input logic [15:0] off,
                                        input int lsb);
    logic [2:0] r;
    logic [15:0] b;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      b = BASE_ADDR[i] + off;
      if ((a >> lsb) == (b >> lsb)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  logic [2:0] isaCmdHit;
  logic [2:0] isaCtlHit;
  logic [2:0] isaDrvHit;
  logic [2:0] accDataHit;
  logic isaIdeHit;
  logic isaIdeEnabled;
  logic defaultState;

  assign isaCmdHit = decode(isaAddr, 16'h0000, 3);
  assign isaCtlHit = decode(isaAddr, CTL_OFFSET, 1);
  assign isaDrvHit = decode(isaAddr, DRVSEL_OFFSET, 0);
  assign accDataHit = decode(accAddr, 16'h0000, 0);
  assign isaIdeHit = isaCmdHit[2] || isaCtlHit[2];
  assign isaIdeEnabled = (isaCmdHit[2] && baseEnable[isaCmdHit[1:0]])
      || (isaCtlHit[2] && baseEnable[isaCtlHit[1:0]]);
  assign defaultState = !isaCycleActive && altMasterGrantN;

  ////////////////////////////////////////////////////////////////
  // Drive select bits snooped from select-port writes
  logic [3:0] selBit;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      selBit <= 4'h0;
    end else if (!isaIowN && isaDrvHit[2]) begin
      selBit[isaDrvHit[1:0]] <= isaData4;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Ready synchroniser
  logic readyMeta;
  logic readySync;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readyMeta <= 1'b1;
      readySync <= 1'b1;
    end else begin
      readyMeta <= ideReady;
      readySync <= readyMeta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Drive selection and timing set
  logic [2:0] reqDrive;
  logic reqFast;
  logic [2:0] drive;
  logic useB;
  logic [3:0] rdLen;
  logic [3:0] wrLen;
  logic [3:0] recovCode;
  logic [1:0] asuCode;
  logic [4:0] recovNeed;

  assign reqDrive = {accDataHit[1:0], selBit[accDataHit[1:0]]};
  assign reqFast = accDataHit[2] && baseEnable[accDataHit[1:0]]
      && !(reqDrive < 3'(ISA_ROUTE_DRIVES) && isaRouteDrive[reqDrive[1:0]]);
  assign accToIsa = accReq && !reqFast;
  assign useB = driveTimingB[drive];
  assign rdLen = useB ? rdLenB : rdLenA;
  assign wrLen = useB ? wrLenB : wrLenA;
  assign recovCode = useB ? recovB : recovA;
  assign asuCode = useB ? asuB : asuA;
  assign recovNeed = (recovCode <= RECOV_LINEAR_MAX) ? 5'(recovCode) + 5'h01
      : 5'((recovCode - RECOV_LINEAR_MAX) * 2 + 8);

  ////////////////////////////////////////////////////////////////
  // Fast state machine
  fid_state_type state;
  logic isWrite;
  logic is32;
  logic half;
  logic [31:0] wrData;
  logic [3:0] cmdCnt;
  logic [2:0] setupCnt;
  logic [4:0] recovCnt;
  logic fastRd;
  logic fastWr;
  logic pushValid;
  logic pushReady;
  logic startOk;

  assign fastRd = (state == ST_CMD) && !isWrite;
  assign fastWr = (state == ST_CMD) && isWrite;
  assign startOk = (setupCnt > 3'(asuCode)) && (recovCnt >= recovNeed)
      && (isWrite || pushReady) && !pushValid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setupCnt <= 3'h0;
    end else if (!defaultState) begin
      setupCnt <= 3'h0;
    end else if (setupCnt != SETUP_SAT) begin
      setupCnt <= setupCnt + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      recovCnt <= RECOV_SAT;
    end else if (!ideReadStrobeN || !ideWriteStrobeN || fastRd || fastWr) begin
      recovCnt <= 5'h00;
    end else if (recovCnt != RECOV_SAT) begin
      recovCnt <= recovCnt + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      isWrite <= 1'b0;
      is32 <= 1'b0;
      half <= 1'b0;
      wrData <= 32'h0000_0000;
      drive <= 3'h0;
      cmdCnt <= 4'h0;
      pushValid <= 1'b0;
    end else begin
      pushValid <= fastRd && (cmdCnt == 4'h0) && readySync;
      unique case (state)
        ST_IDLE: begin
          if (accReq && reqFast) begin
            isWrite <= accWrite;
            is32 <= acc32;
            half <= 1'b0;
            wrData <= accWrData;
            drive <= reqDrive;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (startOk && defaultState) begin
            cmdCnt <= isWrite ? wrLen : rdLen;
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cmdCnt != 4'h0) begin
            cmdCnt <= cmdCnt - 4'h1;
          end else if (readySync) begin
            if (is32 && !half) begin
              half <= 1'b1;
              state <= ST_WAIT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  assign accAck = (state == ST_DONE);

  fid_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) readFifo (
    .clk(clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(ideDataIn),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  ////////////////////////////////////////////////////////////////
  // Drive pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ideReadStrobeN <= 1'b1;
      ideWriteStrobeN <= 1'b1;
      ideBufEnableN <= 1'b1;
      ideDataOut <= 16'h0000;
      ideDataOe <= 1'b0;
    end else begin
      ideReadStrobeN <= isaIorN && !fastRd;
      ideWriteStrobeN <= isaIowN && !fastWr;
      ideBufEnableN <= !(((!isaIorN || !isaIowN) && isaIdeHit) || fastRd || fastWr);
      ideDataOut <= half ? wrData[31:16] : wrData[15:0];
      ideDataOe <= fastWr;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      driveCmdSelectN <= DEFAULT_CMD_SEL_N;
      driveCtlSelectN <= DEFAULT_CTL_SEL_N;
      periphAddrLow <= DEFAULT_XA;
      sbheOutN <= DEFAULT_SBHE_N;
    end else if (defaultState) begin
      driveCmdSelectN <= DEFAULT_CMD_SEL_N;
      driveCtlSelectN <= DEFAULT_CTL_SEL_N;
      periphAddrLow <= DEFAULT_XA;
      sbheOutN <= DEFAULT_SBHE_N;
    end else begin
      driveCmdSelectN <= !isaCmdHit[2];
      driveCtlSelectN <= !isaCtlHit[2];
      periphAddrLow <= isaXa;
      if (altMasterGrantN && useA2Subst && isaIdeEnabled) begin
        sbheOutN <= isaAddr[2];
      end else begin
        sbheOutN <= isaSbheN;
      end
    end
  end

  assign boardResetOut = !reset;

  ////////////////////////////////////////////////////////////////
  // Shared floppy bit
  logic floppyRead;

  assign floppyRead = !isaIorN && (isaAddr == FLOPPY_PORT_PRI || isaAddr == FLOPPY_PORT_SEC);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mergedData <= 8'h00;
      mergeActive <= 1'b0;
    end else begin
      mergeActive <= floppyRead;
      if (floppyRead) begin
        mergedData <= {floppyChangeBitIn, ideDataIn[6:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_idle_pattern: assert property (@(posedge clk) disable iff (reset)
    defaultState |=> (!driveCmdSelectN && driveCtlSelectN && periphAddrLow == 2'h0 && !sbheOutN))
    else $error("idle pattern not driven");
  a_isa_read_copy: assert property (@(posedge clk) disable iff (reset)
    !isaIorN |=> !ideReadStrobeN)
    else $error("read command not copied");
  a_buf_enable: assert property (@(posedge clk) disable iff (reset)
    (!isaIowN && isaIdeHit) or fastWr |=> !ideBufEnableN)
    else $error("buffer enable missing");
  a_grant_external: assert property (@(posedge clk) disable iff (reset)
    !altMasterGrantN |=> (periphAddrLow == $past(isaXa) && sbheOutN == $past(isaSbheN)))
    else $error("external address not passed");
  a_a2_subst: assert property (@(posedge clk) disable iff (reset)
    (isaCycleActive && altMasterGrantN && useA2Subst && isaIdeEnabled)
    |=> sbheOutN == $past(isaAddr[2]))
    else $error("A2 not substituted");
  a_no_subst: assert property (@(posedge clk) disable iff (reset)
    (isaCycleActive && !useA2Subst) |=> sbheOutN == $past(isaSbheN))
    else $error("byte high not preserved");
  a_floppy_merge: assert property (@(posedge clk) disable iff (reset)
    floppyRead |=> (mergedData[7] == $past(floppyChangeBitIn) && mergeActive))
    else $error("floppy bit not merged");
  a_ready_hold: assert property (@(posedge clk) disable iff (reset)
    (state == ST_CMD && cmdCnt == 4'h0 && !readySync) |=> state == ST_CMD ##1 !ideReadStrobeN
    || !ideWriteStrobeN)
    else $error("command ended while not ready");
  a_two_halves: assert property (@(posedge clk) disable iff (reset)
    (state == ST_CMD && is32 && !half && cmdCnt == 4'h0 && readySync) |=> state == ST_WAIT)
    else $error("second transfer missing");
  a_reset_out: assert property (@(posedge clk) boardResetOut == !reset)
    else $error("drive reset wrong");
  c_fast_read: cover property (@(posedge clk) disable iff (reset) fastRd ##1 accAck);
  c_fast_write32: cover property (@(posedge clk) disable iff (reset) fastWr && half && is32);
  c_ready_stretch: cover property (@(posedge clk) disable iff (reset)
    state == ST_CMD && cmdCnt == 4'h0 && !readySync);
endmodule

// [fid_drive_model.sv]
`timescale 1ns/1ps
module fid_drive_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic hostOe,
  input wire logic [15:0] hostData,
  input wire logic slowMode,
  output logic [15:0] driveData,
  output logic driveReady,
  output logic wrSeen,
  output logic [15:0] wrWord
);
  logic [15:0] rdCount;
  logic [15:0] word;
  logic [3:0] busyCnt;
  logic prevRd, prevWr;
  // Released bus shows the inverse word
  assign word = 16'hC300 + rdCount * 16'h0003;
  assign driveData = rdStrobeN ? ~word : word;
  assign driveReady = busyCnt == 4'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdCount <= 16'h0000;
      busyCnt <= 4'h0;
      prevRd <= 1'b1;
      prevWr <= 1'b1;
      wrSeen <= 1'b0;
      wrWord <= 16'h0000;
    end else begin
      prevRd <= rdStrobeN;
      prevWr <= wrStrobeN;
      wrSeen <= !prevWr && wrStrobeN;
      if (!wrStrobeN && hostOe) begin
        wrWord <= hostData;
      end
      if (!prevRd && rdStrobeN) begin
        rdCount <= rdCount + 16'h0001;
      end
      if (slowMode && prevRd && !rdStrobeN) begin
        busyCnt <= 4'hC;
      end else if (busyCnt != 4'h0) begin
        busyCnt <= busyCnt - 4'h1;
      end
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  import fid_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic accReq = 1'b0, accWrite = 1'b0, acc32 = 1'b0, rdReady = 1'b0, useA2Subst = 1'b1;
  logic isaCycleActive = 1'b0, altMasterGrantN = 1'b1, isaIorN = 1'b1, isaIowN = 1'b1;
  logic isaSbheN = 1'b0, isaData4 = 1'b0, floppyChangeBitIn = 1'b0, slowMode = 1'b0;
  logic [15:0] accAddr = 16'h01F0, isaAddr = 16'h0000, rdIdx = 16'h0000, a;
  logic [31:0] accWrData = 32'h0;
  logic [3:0] baseEnable = 4'hF, isaRouteDrive = 4'h0, rdLenA = 4'h0, wrLenA = 4'h1;
  logic [3:0] recovA = 4'h2, rdLenB = 4'h2, wrLenB = 4'h3, recovB = 4'h9;
  logic [7:0] driveTimingB = 8'h02, mergedData, mergeExp;
  logic [1:0] asuA = 2'h1, asuB = 2'h3, isaXa = 2'h0, periphAddrLow;
  logic accToIsa, accAck, rdValid, ideDataOe, ideReadStrobeN, ideWriteStrobeN, ideBufEnableN;
  logic driveCmdSelectN, driveCtlSelectN, sbheOutN, boardResetOut, mergeActive, ideReady;
  logic wrSeen, ack, drainOn = 1'b0;
  logic [15:0] rdData, ideDataOut, ideDataIn, wrWord;
  logic [15:0] expQ[$], wrLog[$];
  int n_mismatch = 0, total_checks = 0, lowCnt = 0, lastLow = 0, nStrobe = 0, base, k;
  always #5 clk = ~clk;
  fid_fast_ide i_dut (.clk, .reset, .accReq, .accAddr, .accWrite, .acc32, .accWrData, .accToIsa,
    .accAck, .rdValid, .rdReady, .rdData, .baseEnable, .useA2Subst, .isaRouteDrive, .driveTimingB,
    .rdLenA, .wrLenA, .recovA, .asuA, .rdLenB, .wrLenB, .recovB, .asuB, .isaCycleActive,
    .altMasterGrantN, .isaIorN, .isaIowN, .isaAddr, .isaXa, .isaSbheN, .isaData4, .ideReady,
    .floppyChangeBitIn, .ideDataIn, .ideDataOut, .ideDataOe, .ideReadStrobeN, .ideWriteStrobeN,
    .ideBufEnableN, .driveCmdSelectN, .driveCtlSelectN, .periphAddrLow, .sbheOutN, .boardResetOut,
    .mergedData, .mergeActive);
  fid_drive_model i_drive (.clk, .reset, .rdStrobeN(ideReadStrobeN), .wrStrobeN(ideWriteStrobeN),
    .hostOe(ideDataOe), .hostData(ideDataOut), .slowMode, .driveData(ideDataIn),
    .driveReady(ideReady), .wrSeen, .wrWord);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] expWord(input logic [15:0] n);
    return 16'hC300 + n * 16'h0003;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic waitAck(input int bound, input logic mustAck, output logic got);
    got = 1'b0;
    for (int i = 0; i < bound && !got; i++) begin
      @(posedge clk);
      #1;
      got = accAck === 1'b1;
    end
    if (got) begin
      @(posedge clk);
      accReq <= 1'b0;
    end else if (mustAck) begin
      n_mismatch++;
      $display("[ERR] %0t: acknowledge timed out", $time);
      end_of_test();
    end
  endtask
  task automatic drainWait;
    for (int i = 0; i < 500 && expQ.size() != 0; i++) @(posedge clk);
    check(expQ.size(), 0);
    if (expQ.size() != 0) begin
      end_of_test();
    end
  endtask
  task automatic access(input logic [15:0] ad, input logic wr, input logic w32, input int bound);
    @(posedge clk);
    accReq <= 1'b1;
    accAddr <= ad;
    accWrite <= wr;
    acc32 <= w32;
    accWrData <= $urandom;
    #1 check(accToIsa, 1'b0);
    for (int i = 0; i < (w32 ? 2 : 1) && !wr; i++) begin
      expQ.push_back(expWord(rdIdx));
      rdIdx++;
    end
    // Short bounds mark an expected stall
    waitAck(bound, bound > 100, ack);
  endtask
  task automatic checkIdle;
    repeat (2) @(posedge clk);
    #1 check({driveCtlSelectN, driveCmdSelectN, periphAddrLow, sbheOutN}, 5'h10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!(ideReadStrobeN && ideWriteStrobeN)) begin
      lowCnt++;
    end else if (lowCnt != 0) begin
      lastLow = lowCnt;
      lowCnt = 0;
      nStrobe++;
    end
    if (wrSeen) begin
      wrLog.push_back(wrWord);
    end
    if (rdValid && rdReady) begin
      check(rdData, (expQ.size() != 0) ? {16'h0, expQ.pop_front()} : 32'h10000);
    end
    rdReady <= drainOn && ($urandom_range(0, 3) != 0);
  end
  initial begin
    void'($urandom(32'h0826));
    repeat (3) @(posedge clk);
    check(boardResetOut, 1'b0);
    reset <= 1'b0;
    checkIdle();
    check(boardResetOut, 1'b1);
    $display("test reset done");
    drainOn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdLenA <= 4'($urandom_range(0, 5));
      recovA <= 4'($urandom);
      asuA <= 2'($urandom);
      base = nStrobe;
      access(16'h01F0, 1'b0, i[0], 300);
      repeat (2) @(posedge clk);
      check(ack, 1'b1);
      check(nStrobe - base, i[0] ? 2 : 1);
      check(lastLow, rdLenA + 1);
    end
    @(posedge clk);
    isaAddr <= 16'h01F6;
    isaData4 <= 1'b1;
    isaIowN <= 1'b0;
    @(posedge clk);
    isaIowN <= 1'b1;
    rdLenB <= 4'h8;
    access(16'h01F0, 1'b0, 1'b0, 300);
    repeat (2) @(posedge clk);
    check(lastLow, 9);
    slowMode <= 1'b1;
    access(16'h01F0, 1'b0, 1'b0, 300);
    repeat (2) @(posedge clk);
    check(lastLow > 11 && lastLow < 22, 1'b1);
    slowMode <= 1'b0;
    isaRouteDrive <= 4'hF;
    access(16'h05F0, 1'b0, 1'b0, 300);
    check(ack, 1'b1);
    @(posedge clk);
    accReq <= 1'b1;
    accAddr <= 16'h01F0;
    #1 check(accToIsa, 1'b1);
    @(posedge clk);
    accAddr <= 16'h0172;
    #1 check(accToIsa, 1'b1);
    @(posedge clk);
    accReq <= 1'b0;
    isaRouteDrive <= 4'h0;
    $display("test fast reads done");
    drainWait();
    drainOn <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      access(16'h01F0, 1'b0, 1'b1, 300);
      check(ack, 1'b1);
    end
    access(16'h01F0, 1'b0, 1'b0, 60);
    check(ack, 1'b0);
    drainOn <= 1'b1;
    waitAck(300, 1'b1, ack);
    check(ack, 1'b1);
    drainWait();
    $display("test buffer done");
    wrLog.delete();
    wrLenB <= 4'($urandom_range(0, 7));
    access(16'h01F0, 1'b1, 1'b1, 300);
    repeat (4) @(posedge clk);
    check(wrLog.size(), 2);
    check({wrLog[1], wrLog[0]}, accWrData);
    $display("test write done");
    for (int i = 0; i < 24; i++) begin
      k = $urandom_range(0, 2);
      base = $urandom_range(0, 3);
      a = (k == 2) ? 16'h0300 + 16'($urandom_range(0, 15)) : BASE_ADDR[base]
        + ((k == 1) ? CTL_OFFSET + 16'($urandom_range(0, 1)) : 16'($urandom_range(0, 7)));
      @(posedge clk);
      baseEnable <= 4'($urandom);
      isaCycleActive <= !i[0];
      altMasterGrantN <= !i[0];
      useA2Subst <= (k == 0) && ($urandom_range(0, 1) == 1);
      isaAddr <= a;
      isaXa <= 2'($urandom);
      isaSbheN <= 1'($urandom);
      isaIorN <= 1'($urandom);
      @(posedge clk);
      #1;
      check(driveCmdSelectN, k != 0);
      check(driveCtlSelectN, k != 1);
      check(periphAddrLow, isaXa);
      check(sbheOutN, (!i[0] && useA2Subst && baseEnable[base]) ? a[2] : isaSbheN);
      check(ideReadStrobeN, isaIorN);
      check(ideBufEnableN, isaIorN || k == 2);
    end
    @(posedge clk);
    isaCycleActive <= 1'b0;
    altMasterGrantN <= 1'b1;
    isaIorN <= 1'b1;
    checkIdle();
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      isaAddr <= j[0] ? FLOPPY_PORT_SEC : FLOPPY_PORT_PRI;
      floppyChangeBitIn <= 1'($urandom);
      isaIorN <= 1'b0;
      #1 mergeExp = {floppyChangeBitIn, ideDataIn[6:0]};
      @(posedge clk);
      isaIorN <= 1'b1;
      #1 check({mergeActive, mergedData}, {1'b1, mergeExp});
    end
    $display("test isa done");
    end_of_test();
  end
endmodule
